// *** rtl/sps_setpoint.sv ***
// Our own choices: the register offsets and strobed register access.
`default_nettype none
// Operation
// - Active setpoint kept within floor and ceiling
// - Refuse floor above ceiling
// - Refuse limits outside input range; keep old
// - Floor from input minimum to ceiling minus one
// - Input type change reloads limits
// - Scale change copies smaller/larger into limits for analog input type
// - Remote source module 0 to 48, reset 0
// - Own address from switch plus group
// - Remote channel code, reset own index
// - Selector off, process value, setpoint
// - Refuse setpoint target from analog module; checked on selector write only, not on later module writes
// - Refuse own process value as source; checked on selector write only, not on later module/channel writes
// - Rescale remote across temperature/analog types
// - Clamp remote setpoint to limits
// - Tuning always uses local setpoint
// - Follow-on-release copies remote into local
// - Over range gives 30000, heat full
// - Under range gives -30000, cool full
// - Open/comm errors give codes, error output
module sps_setpoint
    import sps_pkg::*;
#(
    parameter int CHANNEL_INDEX = 0
) (
    // Clock, reset, enable
    input  wire logic         SYS_CLK,
    input  wire logic         RST_N,
    input  wire logic         CE,
    // Register port
    input  wire logic [3:0]   REG_ADDR,
    input  wire logic [15:0]  REG_WDATA,
    input  wire logic         REG_WR,
    input  wire logic         REG_RD,
    output logic      [15:0]  REG_RDATA,
    // Address switch pins
    input  wire logic [3:0]   UNIT_SW,
    input  wire logic [1:0]   MODULE_GROUP,
    // Remote source link
    output var  sps_req_type  REQ,
    input  wire sps_resp_type RESP,
    // Control outputs
    output var  sps_val_type  ACTIVE_SP,
    output var  sps_val_type  TUNE_SP,
    output logic              HEAT_FULL,
    output logic              COOL_FULL,
    output logic              SENSOR_ERR_MV,
    output var  sps_val_type  MULTI_SP,
    output logic              MULTI_SP_WE
);
    if (CHANNEL_INDEX < 0 || CHANNEL_INDEX > 3) begin : g_bad_channel
        $error("CHANNEL_INDEX must lie in 0 to 3");
    end

    localparam logic [1:0] OWN_CH = 2'(CHANNEL_INDEX);

    typedef struct packed {
        logic [3:0]     sw_s1;
        logic [3:0]     sw_s2;
        logic [1:0]     grp_s1;
        logic [1:0]     grp_s2;
        logic [5:0]     own_addr;
        logic           analog;
        logic [1:0]     kind;
        sps_val_type    scale_a;
        sps_val_type    scale_b;
        sps_val_type    floor;
        sps_val_type    ceil;
        sps_val_type    local_sp;
        sps_val_type    act_sp;
        sps_val_type    using_val;
        logic [5:0]     src_mod;
        logic [1:0]     src_ch;
        sps_sel_type    sel;
        logic           follow;
        sps_rstate_type state;
        sps_status_type last_st;
        logic           heat_full;
        logic           cool_full;
        logic           sens_err;
        logic           store_we;
        logic [15:0]    rdata;
    } sps_state_type;

    sps_state_type q_r;
    sps_state_type q_nxt;
    logic [1:0]    rst_sync_r;
    logic          rst_n_i;
    sps_val_type   in_min;
    sps_val_type   in_max;
    sps_val_type   wd;
    sps_val_type   conv;
    sps_val_type   clamp_in;
    sps_val_type   clamp_out;
    logic          resp_ok;
    logic          wr;
    logic          rd;

    ////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_i = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////
    // Datapath helpers
    assign wd      = REG_WDATA;
    assign wr      = REG_WR && CE;
    assign rd      = REG_RD && CE;
    assign resp_ok = RESP.valid && (RESP.status == ST_OK)
                     && (q_r.sel != SEL_OFF);

    always_comb begin
        if (q_r.analog) begin
            in_min = sps_min(q_r.scale_a, q_r.scale_b);
            in_max = sps_max(q_r.scale_a, q_r.scale_b);
        end else begin
            in_min = TEMP_MIN[q_r.kind];
            in_max = TEMP_MAX[q_r.kind];
        end
    end

    sps_rescale u_rescale (
        .en   (RESP.analog != q_r.analog),
        .v    (RESP.value),
        .smin (RESP.range_min),
        .smax (RESP.range_max),
        .dmin (in_min),
        .dmax (in_max),
        .y    (conv)
    );

    // One clamp serves local, remote and limit changes alike
    assign clamp_in = (q_r.sel == SEL_OFF) ? q_r.local_sp
                    : (resp_ok ? conv : q_r.act_sp);
    sps_clamp u_clamp (
        .x  (clamp_in),
        .lo (q_r.floor),
        .hi (q_r.ceil),
        .y  (clamp_out)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        q_nxt          = q_r;
        q_nxt.store_we = 1'b0;
        q_nxt.rdata    = 16'h0000;
        q_nxt.sw_s1    = UNIT_SW;
        q_nxt.sw_s2    = q_r.sw_s1;
        q_nxt.grp_s1   = MODULE_GROUP;
        q_nxt.grp_s2   = q_r.grp_s1;
        // Switch zero is the last address of its group; for group 3 it wraps to 0
        if (q_r.sw_s2 == 4'h0) begin
            q_nxt.own_addr = 6'(q_r.grp_s2 + 2'd1) * GROUP_STEP;
        end else begin
            q_nxt.own_addr = 6'(q_r.grp_s2) * GROUP_STEP
                           + 6'(q_r.sw_s2);
        end
        q_nxt.act_sp = clamp_out;

        // Remote source tracking
        unique case (q_r.state)
            RS_OFF: begin
                if (q_r.sel != SEL_OFF) begin
                    q_nxt.state = RS_WAIT;
                end
            end
            RS_WAIT, RS_LIVE: begin
                if (q_r.sel == SEL_OFF) begin
                    q_nxt.state = RS_OFF;
                end else if (RESP.valid) begin
                    q_nxt.state = resp_ok ? RS_LIVE : RS_WAIT;
                end
            end
            default: begin
                q_nxt.state = RS_OFF;
            end
        endcase

        if (q_r.sel == SEL_OFF) begin
            q_nxt.heat_full = 1'b0;
            q_nxt.cool_full = 1'b0;
            q_nxt.sens_err  = 1'b0;
            q_nxt.using_val = q_r.act_sp;
        end else if (RESP.valid) begin
            q_nxt.last_st   = RESP.status;
            q_nxt.heat_full = 1'b0;
            q_nxt.cool_full = 1'b0;
            q_nxt.sens_err  = 1'b0;
            unique case (RESP.status)
                ST_OK: begin
                    q_nxt.using_val = conv;
                end
                ST_OVER: begin
                    q_nxt.using_val = OVER_RANGE_CODE;
                    q_nxt.heat_full = 1'b1;
                end
                ST_UNDER: begin
                    q_nxt.using_val = UNDER_RANGE_CODE;
                    q_nxt.cool_full = 1'b1;
                end
                ST_OPEN: begin
                    q_nxt.using_val = OPEN_CODE;
                    q_nxt.sens_err  = 1'b1;
                end
                ST_ICOMM: begin
                    q_nxt.using_val = ICOMM_CODE;
                    q_nxt.sens_err  = 1'b1;
                end
                default: begin
                    q_nxt.using_val = CHCOMM_CODE;
                    q_nxt.sens_err  = 1'b1;
                end
            endcase
        end

        // Register writes; refused writes leave the old value
        if (wr) begin
            unique case (REG_ADDR)
                IX_INTYPE: begin
                    q_nxt.analog = wd[INTYPE_ANALOG_BIT];
                    q_nxt.kind   = wd[1:0];
                    if (wd[INTYPE_ANALOG_BIT]) begin
                        q_nxt.floor = sps_min(q_r.scale_a, q_r.scale_b);
                        q_nxt.ceil  = sps_max(q_r.scale_a, q_r.scale_b);
                    end else begin
                        q_nxt.floor = TEMP_MIN[wd[1:0]];
                        q_nxt.ceil  = TEMP_MAX[wd[1:0]];
                    end
                end
                IX_SCALE_A, IX_SCALE_B: begin
                    // Equal scale ends would give an empty range
                    if (REG_ADDR == IX_SCALE_A && wd != q_r.scale_b) begin
                        q_nxt.scale_a = wd;
                    end
                    if (REG_ADDR == IX_SCALE_B && wd != q_r.scale_a) begin
                        q_nxt.scale_b = wd;
                    end
                    if (q_r.analog) begin
                        q_nxt.floor = sps_min(q_nxt.scale_a, q_nxt.scale_b);
                        q_nxt.ceil  = sps_max(q_nxt.scale_a, q_nxt.scale_b);
                    end
                end
                IX_FLOOR: begin
                    if (wd >= in_min && wd < q_r.ceil) begin
                        q_nxt.floor = wd;
                    end
                end
                IX_CEIL: begin
                    if (wd > q_r.floor && wd <= in_max) begin
                        q_nxt.ceil = wd;
                    end
                end
                IX_LOCAL: begin
                    if (wd >= q_r.floor && wd <= q_r.ceil) begin
                        q_nxt.local_sp = wd;
                    end
                end
                IX_SRC_MOD: begin
                    if (REG_WDATA[15:6] == 10'h000
                        && REG_WDATA[5:0] <= MOD_ADDR_MAX) begin
                        q_nxt.src_mod = REG_WDATA[5:0];
                    end
                end
                IX_SRC_CH: begin
                    q_nxt.src_ch = REG_WDATA[1:0];
                end
                IX_SRC_SEL: begin
                    if (REG_WDATA[15:2] != 14'h0000) begin
                        q_nxt.sel = q_r.sel;
                    end else if (REG_WDATA[1:0] == SEL_OFF) begin
                        q_nxt.sel = SEL_OFF;
                        // Avoids a step in output on release
                        if (q_r.sel != SEL_OFF && q_r.follow) begin
                            q_nxt.local_sp = q_r.act_sp;
                            q_nxt.store_we = 1'b1;
                        end
                    end else if (REG_WDATA[1:0] == SEL_PV) begin
                        if (!(q_r.src_mod == 6'h00
                              && q_r.src_ch == OWN_CH)) begin
                            q_nxt.sel = SEL_PV;
                        end
                    end else if (REG_WDATA[1:0] == SEL_SV) begin
                        if (q_r.src_mod < ANALOG_MOD_BASE) begin
                            q_nxt.sel = SEL_SV;
                        end
                    end
                end
                IX_FOLLOW: begin
                    q_nxt.follow = REG_WDATA[0];
                end
                default: begin
                end
            endcase
        end

        // Register reads, data in the following cycle only
        if (rd) begin
            unique case (REG_ADDR)
                IX_INTYPE:  q_nxt.rdata = {13'h0000, q_r.analog, q_r.kind};
                IX_SCALE_A: q_nxt.rdata = q_r.scale_a;
                IX_SCALE_B: q_nxt.rdata = q_r.scale_b;
                IX_FLOOR:   q_nxt.rdata = q_r.floor;
                IX_CEIL:    q_nxt.rdata = q_r.ceil;
                IX_LOCAL:   q_nxt.rdata = q_r.local_sp;
                IX_SRC_MOD: q_nxt.rdata = {10'h000, q_r.src_mod};
                IX_SRC_CH:  q_nxt.rdata = {14'h0000, q_r.src_ch};
                IX_SRC_SEL: q_nxt.rdata = {14'h0000, q_r.sel};
                IX_FOLLOW:  q_nxt.rdata = {15'h0000, q_r.follow};
                IX_STATUS:  q_nxt.rdata = {5'h00, q_r.last_st,
                                           q_r.state, q_r.own_addr};
                IX_ACTIVE:  q_nxt.rdata = q_r.act_sp;
                IX_USING:   q_nxt.rdata = q_r.using_val;
                default:    q_nxt.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge SYS_CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_r          <= '0;
            q_r.scale_a  <= SCALE_A_RST;
            q_r.scale_b  <= SCALE_B_RST;
            q_r.floor    <= FLOOR_RST;
            q_r.ceil     <= CEIL_RST;
            q_r.local_sp <= LOCAL_RST;
            q_r.act_sp   <= LOCAL_RST;
            q_r.using_val <= LOCAL_RST;
            q_r.src_ch   <= OWN_CH;
            q_r.sel      <= SEL_OFF;
            q_r.state    <= RS_OFF;
            q_r.last_st  <= ST_OK;
        end else if (CE) begin
            q_r <= q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign REG_RDATA        = q_r.rdata;
    assign REQ.en           = (q_r.sel != SEL_OFF);
    assign REQ.module_addr  = q_r.src_mod;
    assign REQ.channel      = q_r.src_ch;
    assign REQ.selector     = q_r.sel;
    assign ACTIVE_SP        = q_r.act_sp;
    assign TUNE_SP          = q_r.local_sp;
    assign HEAT_FULL        = q_r.heat_full;
    assign COOL_FULL        = q_r.cool_full;
    assign SENSOR_ERR_MV    = q_r.sens_err;
    assign MULTI_SP         = q_r.local_sp;
    assign MULTI_SP_WE      = q_r.store_we;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n_i);

    a_limits_ordered: assert property (q_r.floor < q_r.ceil)
        else $error("floor not below ceiling");
    a_active_inside: assert property (
        ($past(CE) && $stable(q_r.floor) && $stable(q_r.ceil)) |->
        (q_r.act_sp >= q_r.floor && q_r.act_sp <= q_r.ceil))
        else $error("active setpoint outside limits");
    a_src_mod_max: assert property (q_r.src_mod <= MOD_ADDR_MAX)
        else $error("remote module above 48");
    a_sel_legal: assert property (q_r.sel != 2'h3)
        else $error("illegal selector code");
    a_sv_refused: assert property (
        (wr && REG_ADDR == IX_SRC_SEL && REG_WDATA == 16'h0002
         && q_r.src_mod >= ANALOG_MOD_BASE)
        |=> q_r.sel == $past(q_r.sel))
        else $error("setpoint target taken from analog module");
    a_pv_refused: assert property (
        (wr && REG_ADDR == IX_SRC_SEL && REG_WDATA == 16'h0001
         && q_r.src_mod == 6'h00 && q_r.src_ch == OWN_CH)
        |=> q_r.sel == $past(q_r.sel))
        else $error("own process value taken as source");
    a_over_code: assert property (
        (CE && RESP.valid && RESP.status == ST_OVER && q_r.sel != SEL_OFF)
        |=> q_r.using_val == OVER_RANGE_CODE
            && HEAT_FULL && !COOL_FULL)
        else $error("over range handling wrong");
    a_under_code: assert property (
        (CE && RESP.valid && RESP.status == ST_UNDER && q_r.sel != SEL_OFF)
        |=> q_r.using_val == UNDER_RANGE_CODE
            && COOL_FULL && !HEAT_FULL)
        else $error("under range handling wrong");
    a_comm_codes: assert property (
        (CE && RESP.valid && RESP.status == ST_ICOMM && q_r.sel != SEL_OFF)
        |=> q_r.using_val == ICOMM_CODE && SENSOR_ERR_MV)
        else $error("communication error handling wrong");
    a_follow_copy: assert property (
        (wr && REG_ADDR == IX_SRC_SEL && REG_WDATA == 16'h0000
         && q_r.sel != SEL_OFF && q_r.follow)
        |=> MULTI_SP_WE && q_r.local_sp == $past(q_r.act_sp)
        ##1 !MULTI_SP_WE)
        else $error("follow on release did not copy");
    a_off_local: assert property (
        (CE && q_r.sel == SEL_OFF && !wr) ##1 CE |=>
        q_r.act_sp == sps_max($past(q_r.floor),
                      sps_min($past(q_r.local_sp), $past(q_r.ceil))))
        else $error("active setpoint not local while off");

    c_remote_live: cover property (q_r.state == RS_LIVE);
    c_follow: cover property (MULTI_SP_WE);
    c_over: cover property (HEAT_FULL);
    c_open: cover property (SENSOR_ERR_MV);
endmodule
`default_nettype wire

// *** rtl/sps_pkg.sv ***
`default_nettype none
package sps_pkg;
    typedef logic signed [15:0] sps_val_type;

    // Register word indices
    localparam logic [3:0] IX_INTYPE  = 4'h0;
    localparam logic [3:0] IX_SCALE_A = 4'h1;
    localparam logic [3:0] IX_SCALE_B = 4'h2;
    localparam logic [3:0] IX_FLOOR   = 4'h3;
    localparam logic [3:0] IX_CEIL    = 4'h4;
    localparam logic [3:0] IX_LOCAL   = 4'h5;
    localparam logic [3:0] IX_SRC_MOD = 4'h6;
    localparam logic [3:0] IX_SRC_CH  = 4'h7;
    localparam logic [3:0] IX_SRC_SEL = 4'h8;
    localparam logic [3:0] IX_FOLLOW  = 4'h9;
    localparam logic [3:0] IX_STATUS  = 4'hA;
    localparam logic [3:0] IX_ACTIVE  = 4'hB;
    localparam logic [3:0] IX_USING   = 4'hC;

    // Input type field
    localparam int INTYPE_ANALOG_BIT = 2;

    // Reset values
    localparam sps_val_type FLOOR_RST   = 16'hFF38;
    localparam sps_val_type CEIL_RST    = 16'h0546;
    localparam sps_val_type SCALE_A_RST = 16'h0000;
    localparam sps_val_type SCALE_B_RST = 16'h03E8;
    localparam sps_val_type LOCAL_RST   = 16'h0000;

    // Temperature sensor kinds: operating range per kind
    localparam sps_val_type TEMP_MIN [4] =
        '{16'hFF38, 16'hFF9C, 16'h0000, 16'hFF39};
    localparam sps_val_type TEMP_MAX [4] =
        '{16'h0546, 16'h01F4, 16'h0190, 16'h0352};

    // Module addressing
    localparam logic [5:0] MOD_ADDR_MAX    = 6'h30;
    localparam logic [5:0] ANALOG_MOD_BASE = 6'h21;
    localparam logic [5:0] GROUP_STEP      = 6'h10;

    // Remote error codes
    localparam sps_val_type OVER_RANGE_CODE  = 16'h7530;
    localparam sps_val_type UNDER_RANGE_CODE = 16'h8AD0;
    localparam sps_val_type OPEN_CODE        = 16'h7918;
    localparam sps_val_type ICOMM_CODE       = 16'h7D00;
    localparam sps_val_type CHCOMM_CODE      = 16'h7B0C;

    typedef enum logic [1:0] {
        SEL_OFF = 2'h0, SEL_PV = 2'h1, SEL_SV = 2'h2
    } sps_sel_type;

    typedef enum logic [1:0] {
        RS_OFF = 2'b00, RS_WAIT = 2'b01, RS_LIVE = 2'b11
    } sps_rstate_type;

    typedef enum logic [2:0] {
        ST_OK = 3'h0, ST_OVER = 3'h1, ST_UNDER = 3'h2,
        ST_OPEN = 3'h3, ST_ICOMM = 3'h4, ST_CHCOMM = 3'h5
    } sps_status_type;

    typedef struct packed {
        logic        en;
        logic [5:0]  module_addr;
        logic [1:0]  channel;
        sps_sel_type selector;
    } sps_req_type;

    typedef struct packed {
        logic           valid;
        sps_status_type status;
        sps_val_type    value;
        logic           analog;
        sps_val_type    range_min;
        sps_val_type    range_max;
    } sps_resp_type;

    function automatic sps_val_type sps_min(sps_val_type a, sps_val_type b);
        return (a < b) ? a : b;
    endfunction

    function automatic sps_val_type sps_max(sps_val_type a, sps_val_type b);
        return (a < b) ? b : a;
    endfunction
endpackage
`default_nettype wire

// *** rtl/sps_clamp.sv ***
`default_nettype none
module sps_clamp
    import sps_pkg::*;
(
    // Value and bounds
    input  wire sps_val_type x,
    input  wire sps_val_type lo,
    input  wire sps_val_type hi,
    // Result
    output var  sps_val_type y
);
    always_comb begin
        if (x < lo) begin
            y = lo;
        end else if (x > hi) begin
            y = hi;
        end else begin
            y = x;
        end
    end
endmodule
`default_nettype wire

// *** rtl/sps_rescale.sv ***
`default_nettype none
module sps_rescale
    import sps_pkg::*;
(
    // Control
    input  wire logic        en,
    // Source value and ranges
    input  wire sps_val_type v,
    input  wire sps_val_type smin,
    input  wire sps_val_type smax,
    input  wire sps_val_type dmin,
    input  wire sps_val_type dmax,
    // Result
    output var  sps_val_type y
);
    logic signed [16:0] num;
    logic signed [16:0] span;
    logic signed [16:0] den;
    logic signed [33:0] prod;
    logic signed [33:0] quo;

    // Same position in proportion of each range
    always_comb begin
        num  = 17'(v) - 17'(smin);
        span = 17'(dmax) - 17'(dmin);
        den  = 17'(smax) - 17'(smin);
        prod = 34'(num) * 34'(span);
        // Degenerate source range maps to the bottom
        // Signed zero keeps the division signed for values below smin
        quo  = (den == 17'h0_0000) ? 34'sh0 : prod / 34'(den);
        y    = en ? sps_val_type'(dmin + sps_val_type'(quo)) : v;
    end
endmodule
`default_nettype wire

// *** tb/sps_partner.sv ***
`default_nettype none
module sps_partner
    import sps_pkg::*;
#(
    parameter int LAT = 2
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // Link
    input  wire sps_req_type    req,
    output var  sps_resp_type   resp,
    // Scenario control
    input  wire logic           go,
    input  wire sps_status_type st,
    input  wire sps_val_type    v,
    input  wire logic           an
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            resp <= '0;
        end else begin
            resp.valid <= 1'b0;
            // Idle data toggles so stale values are never trusted
            resp.value <= ~resp.value;
            if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            if (cnt == 0 && go && req.en) begin
                cnt <= LAT;
            end
            if (cnt == 1) begin
                resp.valid <= 1'b1;
                resp.status <= st;
                resp.value <= v;
                resp.analog <= an;
                resp.range_min <= 16'h0000;
                resp.range_max <= 16'h03E8;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb
    import sps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic           SYS_CLK = 0, RST_N = 0, wr = 0, rd = 0, go = 0, an = 0;
    logic [3:0]     adr = '0;
    logic [3:0]     sw = 4'h0;
    logic [15:0]    wd = '0, rdata;
    sps_req_type    req;
    sps_resp_type   resp;
    sps_status_type st = ST_OK;
    sps_val_type    v = '0, act, tune, msp;
    logic           heat, cool, serr, mwe;
    int             fail_count = 0, checked = 0, cyc = 0;
    sps_val_type    codes [5] = '{OVER_RANGE_CODE, UNDER_RANGE_CODE,
                                  OPEN_CODE, ICOMM_CODE, CHCOMM_CODE};
    logic [2:0]     flg [5] = '{3'b100, 3'b010, 3'b001, 3'b001, 3'b001};

    always #50 SYS_CLK = ~SYS_CLK;

    sps_setpoint #(.CHANNEL_INDEX(2)) i_sps_setpoint (.SYS_CLK(SYS_CLK),
        .RST_N(RST_N), .CE(1'b1), .REG_ADDR(adr), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .UNIT_SW(sw),
        .MODULE_GROUP(2'h1), .REQ(req), .RESP(resp), .ACTIVE_SP(act),
        .TUNE_SP(tune), .HEAT_FULL(heat), .COOL_FULL(cool),
        .SENSOR_ERR_MV(serr), .MULTI_SP(msp), .MULTI_SP_WE(mwe));
    sps_partner i_sps_partner (.clk(SYS_CLK), .rst_n(RST_N), .req(req),
        .resp(resp), .go(go), .st(st), .v(v), .an(an));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wrt(input logic [3:0] a, input logic [15:0] d);
        @(posedge SYS_CLK);
        wr <= 1'b1;
        adr <= a;
        wd <= d;
        @(posedge SYS_CLK);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e,
                       input logic [15:0] m = 16'hFFFF);
        @(posedge SYS_CLK);
        rd <= 1'b1;
        adr <= a;
        @(posedge SYS_CLK);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    // Fixed wait of four cycles covers the partner latency of two
    task automatic fire(input sps_status_type s, input sps_val_type x,
                        input logic a);
        @(posedge SYS_CLK);
        go <= 1'b1;
        st <= s;
        v <= x;
        an <= a;
        @(posedge SYS_CLK);
        go <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            final_report;
        end
    end

    initial begin
        repeat (3) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        rdc(IX_FLOOR, FLOOR_RST);
        rdc(IX_SRC_CH, 16'h0002);
        rdc(IX_SRC_MOD, 16'h0000);
        rdc(IX_SRC_SEL, 16'h0000);
        rdc(IX_STATUS, 16'h0020, 16'h003F);
        @(posedge SYS_CLK) sw <= 4'h5;
        $display("test reset done");
        wrt(IX_FLOOR, CEIL_RST);
        rdc(IX_FLOOR, FLOOR_RST);
        wrt(IX_FLOOR, 16'h0545);
        rdc(IX_FLOOR, 16'h0545);
        rdc(IX_ACTIVE, 16'h0545);
        wrt(IX_FLOOR, 16'hFF37);
        rdc(IX_FLOOR, 16'h0545);
        wrt(IX_CEIL, 16'h0547);
        rdc(IX_CEIL, CEIL_RST);
        wrt(IX_INTYPE, 16'h0001);
        rdc(IX_FLOOR, 16'hFF9C);
        rdc(IX_CEIL, 16'h01F4);
        wrt(IX_INTYPE, 16'h0004);
        rdc(IX_CEIL, SCALE_B_RST);
        wrt(IX_SCALE_A, 16'h07D0);
        rdc(IX_FLOOR, SCALE_B_RST);
        rdc(IX_CEIL, 16'h07D0);
        wrt(IX_INTYPE, 16'h0000);
        wrt(IX_LOCAL, 16'h0000);
        wrt(IX_LOCAL, 16'h0547);
        rdc(IX_ACTIVE, 16'h0000);
        rdc(IX_STATUS, 16'h0015, 16'h003F);
        $display("test limits done");
        wrt(IX_SRC_MOD, 16'h0000);
        wrt(IX_SRC_SEL, 16'h0001);
        rdc(IX_SRC_SEL, 16'h0000);
        wrt(IX_SRC_MOD, 16'h0031);
        rdc(IX_SRC_MOD, 16'h0000);
        wrt(IX_SRC_MOD, 16'h0021);
        wrt(IX_SRC_SEL, 16'h0002);
        rdc(IX_SRC_SEL, 16'h0000);
        wrt(IX_SRC_SEL, 16'h0001);
        wrt(IX_FOLLOW, 16'h0001);
        fire(ST_OK, 16'h07D0, 1'b0);
        rdc(IX_USING, 16'h07D0);
        rdc(IX_ACTIVE, CEIL_RST);
        chk(tune, 16'h0000);
        fire(ST_OK, 16'h01F4, 1'b1);
        rdc(IX_ACTIVE, 16'h023F);
        for (int i = 0; i < 5; i++) begin
            fire(sps_status_type'(i + 1), 16'h0064, 1'b0);
            rdc(IX_USING, codes[i]);
            chk({13'h0, heat, cool, serr}, {13'h0, flg[i]});
        end
        fire(ST_OK, 16'h0064, 1'b0);
        wrt(IX_SRC_SEL, 16'h0000);
        #1 chk({15'h0, mwe}, 16'h0001);
        chk(msp, 16'h0064);
        rdc(IX_LOCAL, 16'h0064);
        $display("test remote done");
        final_report;
    end
endmodule
`default_nettype wire
